// file: rtl/bgm_params.svh
// constants of the burst gate timing block
// assumes a 125 MHz clk and ns-valued settings
// What this block does
// - burst sub-functions run only in burst mode, never in continuous-wave mode
// - three sub-functions: carrier frequency, burst width, burst period
// - width: time burst-on at positive polarity, burst-off at negative
// - period: on-start to on-start when positive, off-start to off-start when negative
// - each polarity write with bit 0 set toggles polarity
// - narrow setting acts only at manual frequency of 1 GHz or more
// - gate placed from trigger by delay, width and gate-end setting
// - trigger delay range 0 ns to 100 ms
// - delay step 20 ns to 320 ns, 40 ns to 1 us, then two digits
// - gate width range 100 ns to 100 ms
// - width step 20 ns up to 1 us, then two digits
// - wide mode: gate never shorter than 1 us while gate end is on
// - delay up/down moves one step, kept in range
// - width up/down moves one step, kept in range
// - gate end on: stop at width; off: count until burst goes off
// - selectable edge for external and line triggers
// - burst mode always counts reciprocally
`ifndef BGM_PARAMS_SVH
`define BGM_PARAMS_SVH
`define BGM_CLK_NS 8
`define BGM_OFS_CTRL 8'h00
`define BGM_OFS_POL 8'h04
`define BGM_OFS_MANF 8'h08
`define BGM_OFS_DELAY 8'h0c
`define BGM_OFS_STEP 8'h10
`define BGM_OFS_WIDTH 8'h14
`define BGM_OFS_STAT 8'h18
`define BGM_OFS_RES 8'h1c
`define BGM_CTRL_BURST 0
`define BGM_CTRL_SUB 2:1
`define BGM_CTRL_NARROW 3
`define BGM_CTRL_GEND 4
`define BGM_CTRL_SLOPE 5
`define BGM_CTRL_TSRC 7:6
`define BGM_CTRL_DIRECT 8
`define BGM_CTRL_RST 9'h010
`define BGM_MANF_RST 16'h4e20
`define BGM_NARROW_MHZ 16'd1000
`define BGM_DLY_MIN_NS 27'd0
`define BGM_DLY_MAX_NS 27'd100000000
`define BGM_GW_MIN_NS 27'd100
`define BGM_GW_MAX_NS 27'd100000000
`define BGM_DLY_RST_NS 27'd0
`define BGM_GW_RST_NS 27'd1000
`define BGM_FINE_NS 27'd20
`define BGM_MID_NS 27'd40
`define BGM_MID_EDGE_NS 27'd320
`define BGM_WIDE_MIN_NS 27'd1000
`endif

// file: rtl/bgm_pkg.sv
// types of the burst gate timing block
// assumes nothing
package bgm_pkg;
  typedef enum logic [1:0] {SUB_FREQ = 2'd0, SUB_WIDTH = 2'd1, SUB_PERIOD = 2'd2} bgm_sub_e;
  typedef enum logic [1:0] {TRG_INT = 2'd0, TRG_EXT = 2'd1, TRG_LINE = 2'd2} bgm_trig_e;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_DELAY = 5'b00010, S_GATE = 5'b00100,
    S_WAIT = 5'b01000, S_TIME = 5'b10000
  } bgm_state_e;
endpackage

// file: rtl/bgm_setting.sv
// one stepped ns setting with up/down and direct load
// assumes one-cycle up, down and load pulses
`timescale 1ns/100ps
`default_nettype none
`include "bgm_params.svh"
module bgm_setting import bgm_pkg::*; #(
  parameter logic [26:0] MIN_NS = 27'd0,
  parameter logic [26:0] MAX_NS = 27'd100,
  parameter logic [26:0] RST_NS = 27'd0,
  parameter bit MID_STEP = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic up,
  input wire logic down,
  input wire logic load,
  input wire logic [26:0] load_ns,
  output logic [26:0] value_ns
);
  logic [26:0] val_q, val_d;
  // *****************************
  // resolution by range
  // *****************************
  function automatic logic [26:0] step_of(input logic [26:0] v);
    if (MID_STEP && v < `BGM_MID_EDGE_NS) step_of = `BGM_FINE_NS;
    else if (v < `BGM_WIDE_MIN_NS) step_of = MID_STEP ? `BGM_MID_NS : `BGM_FINE_NS;
    else if (v < 27'd10000) step_of = 27'd100;
    else if (v < 27'd100000) step_of = 27'd1000;
    else if (v < 27'd1000000) step_of = 27'd10000;
    else if (v < 27'd10000000) step_of = 27'd100000;
    else step_of = 27'd1000000;
  endfunction
  function automatic logic [26:0] clamp(input logic [27:0] v);
    if (v < {1'b0, MIN_NS}) clamp = MIN_NS;
    else if (v > {1'b0, MAX_NS}) clamp = MAX_NS;
    else clamp = v[26:0];
  endfunction
  always_comb begin
    logic [26:0] s;
    s = step_of(val_q);
    val_d = val_q;
    if (load) begin
      s = step_of(load_ns);
      val_d = clamp({1'b0, load_ns - (load_ns % s)});
    end else if (up) begin
      val_d = clamp({1'b0, val_q} + {1'b0, s});
    end else if (down && val_q > MIN_NS) begin
      s = step_of(val_q - 27'd1);
      val_d = clamp({1'b0, val_q} - {1'b0, s});
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) val_q <= RST_NS;
    else val_q <= val_d;
  end
  assign value_ns = val_q;
  // *****************************
  // checks
  // *****************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_value_range: assert property (val_q >= MIN_NS && val_q <= MAX_NS)
    else $error("setting out of range");
  a_step_up: assert property (up && !load && val_q < MAX_NS |=> val_q > $past(val_q))
    else $error("up did not raise setting");
  a_step_down: assert property (down && !up && !load && val_q > MIN_NS |=> val_q < $past(val_q))
    else $error("down did not lower setting");
endmodule
`default_nettype wire

// file: rtl/bgm_top.sv
// burst gate timing measurement with AHB-Lite registers
// assumes a single AHB-Lite master and asynchronous pins
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "bgm_params.svh"
module bgm_top import bgm_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic burst_env,
  input wire logic carrier_pulse,
  input wire logic ext_trig,
  input wire logic line_trig,
  output logic gate_en,
  output logic reciprocal
);
  // *****************************
  // pin synchronisers
  // *****************************
  logic [3:0] sy1_q, sy2_q, prev_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sy1_q <= 4'h0;
      sy2_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sy1_q <= {line_trig, ext_trig, carrier_pulse, burst_env};
      sy2_q <= sy1_q;
      prev_q <= sy2_q;
    end
  end
  logic env_rise, env_fall, car_rise, ext_edge, line_edge;
  // *****************************
  // registers
  // *****************************
  logic [8:0] ctrl_q, ctrl_d;
  logic pol_q, pol_d;
  logic [15:0] manf_q, manf_d;
  logic [31:0] res_q, res_d;
  logic valid_q, valid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0] aaddr_q, aaddr_d;
  logic awr_q, awr_d;
  logic addr_ok;
  logic wr_ctrl, wr_pol, wr_manf, wr_dly, wr_step, wr_gw, rd_res;
  logic [26:0] dly_ns, gw_ns, gate_ns;
  logic burst_on, narrow_eff, gate_end, done;
  bgm_sub_e sub;
  bgm_state_e state_q, state_d;
  logic [24:0] timer_q, timer_d;
  logic [31:0] cnt_q, cnt_d;
  logic [24:0] dly_cyc, gate_cyc;
  logic trig, start_edge, end_edge;
  assign env_rise = sy2_q[0] & ~prev_q[0];
  assign env_fall = ~sy2_q[0] & prev_q[0];
  assign car_rise = sy2_q[1] & ~prev_q[1];
  assign ext_edge = ctrl_q[`BGM_CTRL_SLOPE] ? (~sy2_q[2] & prev_q[2]) : (sy2_q[2] & ~prev_q[2]);
  assign line_edge = ctrl_q[`BGM_CTRL_SLOPE] ? (~sy2_q[3] & prev_q[3]) : (sy2_q[3] & ~prev_q[3]);
  assign addr_ok = hsel & htrans[1] & hready;
  assign wr_ctrl = awr_q && aaddr_q == `BGM_OFS_CTRL;
  assign wr_pol = awr_q && aaddr_q == `BGM_OFS_POL && hwdata[0];
  assign wr_manf = awr_q && aaddr_q == `BGM_OFS_MANF;
  assign wr_dly = awr_q && aaddr_q == `BGM_OFS_DELAY;
  assign wr_step = awr_q && aaddr_q == `BGM_OFS_STEP;
  assign wr_gw = awr_q && aaddr_q == `BGM_OFS_WIDTH;
  assign rd_res = addr_ok && !hwrite && haddr[7:0] == `BGM_OFS_RES;
  assign burst_on = ctrl_q[`BGM_CTRL_BURST];
  assign sub = bgm_sub_e'(ctrl_q[`BGM_CTRL_SUB]);
  assign gate_end = ctrl_q[`BGM_CTRL_GEND];
  assign narrow_eff = ctrl_q[`BGM_CTRL_NARROW] && manf_q >= `BGM_NARROW_MHZ;
  assign gate_ns = (!narrow_eff && gw_ns < `BGM_WIDE_MIN_NS) ? `BGM_WIDE_MIN_NS : gw_ns;
  assign dly_cyc = 25'((dly_ns + 27'(`BGM_CLK_NS - 1)) / 27'(`BGM_CLK_NS));
  assign gate_cyc = 25'((gate_ns + 27'(`BGM_CLK_NS - 1)) / 27'(`BGM_CLK_NS));
  assign reciprocal = burst_on | ~ctrl_q[`BGM_CTRL_DIRECT];
  always_comb begin
    ctrl_d = ctrl_q;
    pol_d = pol_q;
    manf_d = manf_q;
    aaddr_d = addr_ok ? haddr[7:0] : aaddr_q;
    awr_d = addr_ok & hwrite;
    rdata_d = rdata_q;
    if (wr_ctrl) ctrl_d = hwdata[8:0];
    if (wr_pol) pol_d = ~pol_q;
    if (wr_manf) manf_d = hwdata[15:0];
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        `BGM_OFS_CTRL: rdata_d = {23'h0, ctrl_q};
        `BGM_OFS_POL: rdata_d = {31'h0, pol_q};
        `BGM_OFS_MANF: rdata_d = {16'h0, manf_q};
        `BGM_OFS_DELAY: rdata_d = {5'h0, dly_ns};
        `BGM_OFS_WIDTH: rdata_d = {5'h0, gw_ns};
        `BGM_OFS_STAT: rdata_d = {26'h0, pol_q, narrow_eff, reciprocal, valid_q, gate_en, ~state_q[0]};
        `BGM_OFS_RES: rdata_d = res_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `BGM_CTRL_RST;
      pol_q <= 1'b0;
      manf_q <= `BGM_MANF_RST;
      aaddr_q <= 8'h00;
      awr_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ctrl_q <= ctrl_d;
      pol_q <= pol_d;
      manf_q <= manf_d;
      aaddr_q <= aaddr_d;
      awr_q <= awr_d;
      rdata_q <= rdata_d;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  // *****************************
  // delay and width settings
  // *****************************
  // delay resolution table
  bgm_setting #(.MIN_NS(`BGM_DLY_MIN_NS), .MAX_NS(`BGM_DLY_MAX_NS),
    .RST_NS(`BGM_DLY_RST_NS), .MID_STEP(1'b1)) u_delay (
    .clk(clk),
    .rstn(rstn),
    .up(wr_step & hwdata[0]),
    .down(wr_step & hwdata[1]),
    .load(wr_dly),
    .load_ns(hwdata[26:0]),
    .value_ns(dly_ns)
  );
  bgm_setting #(.MIN_NS(`BGM_GW_MIN_NS), .MAX_NS(`BGM_GW_MAX_NS),
    .RST_NS(`BGM_GW_RST_NS), .MID_STEP(1'b0)) u_width (
    .clk(clk),
    .rstn(rstn),
    .up(wr_step & hwdata[2]),
    .down(wr_step & hwdata[3]),
    .load(wr_gw),
    .load_ns(hwdata[26:0]),
    .value_ns(gw_ns)
  );
  // *****************************
  // measurement sequencer
  // *****************************
  always_comb begin
    unique case (bgm_trig_e'(ctrl_q[`BGM_CTRL_TSRC]))
      TRG_EXT: trig = ext_edge;
      TRG_LINE: trig = line_edge;
      default: trig = env_rise;
    endcase
  end
  // polarity picks on or off interval
  assign start_edge = pol_q ? env_fall : env_rise;
  assign end_edge = pol_q ? env_rise : env_fall;
  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    cnt_d = cnt_q;
    done = 1'b0;
    unique case (state_q)
      S_IDLE: begin
        if (burst_on && sub == SUB_FREQ && trig) begin
          cnt_d = 32'h0;
          if (dly_cyc == 25'd0) begin
            state_d = S_GATE;
            timer_d = gate_cyc;
          end else begin
            state_d = S_DELAY;
            timer_d = dly_cyc;
          end
        end else if (burst_on && (sub == SUB_WIDTH || sub == SUB_PERIOD)) begin
          state_d = S_WAIT;
        end
      end
      S_DELAY: begin
        timer_d = timer_q - 25'd1;
        if (timer_q == 25'd1) begin
          state_d = S_GATE;
          timer_d = gate_cyc;
        end
      end
      S_GATE: begin
        if (car_rise) cnt_d = cnt_q + 32'd1;
        timer_d = timer_q - 25'd1;
        if (gate_end ? timer_q == 25'd1 : env_fall) begin
          state_d = S_IDLE;
          done = 1'b1;
        end
      end
      S_WAIT: begin
        cnt_d = 32'h0;
        if (start_edge) state_d = S_TIME;
      end
      S_TIME: begin
        cnt_d = cnt_q + 32'd1;
        if (sub == SUB_PERIOD ? start_edge : end_edge) begin
          state_d = S_IDLE;
          done = 1'b1;
        end
      end
      default: state_d = S_IDLE;
    endcase
    // no burst work in cw mode
    if (!burst_on) begin
      state_d = S_IDLE;
      done = 1'b0;
    end
    res_d = done ? cnt_d : res_q;
    // result flag: set beats read clear
    valid_d = done | (valid_q & ~rd_res);
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= S_IDLE;
      timer_q <= 25'd0;
      cnt_q <= 32'h0;
      res_q <= 32'h0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      valid_q <= valid_d;
    end
  end
  assign gate_en = state_q == S_GATE;
  // *****************************
  // checks
  // *****************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_delay_last;
    state_q == S_DELAY && timer_q == 25'd1 && burst_on;
  endsequence
  sequence s_gate_open;
    state_q == S_GATE && gate_en;
  endsequence
  a_cw_idle: assert property (!burst_on |=> state_q == S_IDLE)
    else $error("burst work in cw mode");
  a_delay_to_gate: assert property (s_delay_last |=> s_gate_open)
    else $error("gate did not open after delay");
  a_delay_no_count: assert property (state_q == S_DELAY |=> $stable(cnt_q))
    else $error("counted outside gate");
  a_gate_hold: assert property (state_q == S_GATE && gate_end && timer_q > 25'd1 && burst_on
    |=> s_gate_open)
    else $error("gate closed early");
  a_gate_end_off: assert property (state_q == S_GATE && !gate_end && env_fall && burst_on
    |=> state_q == S_IDLE && valid_q)
    else $error("gate not ended by burst off");
  a_pol_toggle: assert property (wr_pol |=> pol_q != $past(pol_q))
    else $error("polarity not toggled");
  a_narrow_low: assert property (manf_q < `BGM_NARROW_MHZ |-> !narrow_eff)
    else $error("narrow below 1 GHz");
  a_wide_min: assert property (!narrow_eff |-> gate_ns >= `BGM_WIDE_MIN_NS)
    else $error("wide gate below 1 us");
  a_recip_burst: assert property (burst_on |-> reciprocal)
    else $error("direct count in burst");
  a_width_end: assert property (state_q == S_TIME && sub == SUB_WIDTH && end_edge && burst_on
    |=> state_q == S_IDLE && res_q == $past(cnt_q) + 32'd1)
    else $error("width result wrong");
  sequence s_time_open;
    state_q == S_TIME && cnt_q == 32'h0;
  endsequence
  a_time_start: assert property (state_q == S_WAIT && start_edge && burst_on |=> s_time_open)
    else $error("timing did not start on start edge");
  a_period_end: assert property (state_q == S_TIME && sub == SUB_PERIOD && start_edge && burst_on
    |=> state_q == S_IDLE && res_q == $past(cnt_q) + 32'd1)
    else $error("period result wrong");
  a_gate_count: assert property (state_q == S_GATE && car_rise && burst_on
    |=> cnt_q == $past(cnt_q) + 32'd1)
    else $error("carrier edge not counted");
  a_zero_delay: assert property (state_q == S_IDLE && burst_on && sub == SUB_FREQ && trig && dly_cyc == 25'd0
    |=> s_gate_open)
    else $error("zero delay did not open gate");
  a_trig_ignored: assert property (state_q == S_GATE && gate_end && timer_q > 25'd1 && trig && burst_on
    |=> timer_q == $past(timer_q) - 25'd1)
    else $error("trigger restarted running gate");
endmodule
`default_nettype wire

// file: sim/bgm_env_model.sv
// burst envelope and prescaled carrier source
// assumes run is raised by the bench after reset
`timescale 1ns/100ps
`default_nettype none
module bgm_env_model #(
  parameter int ON_NS = 3000,
  parameter int OFF_NS = 2000
) (
  input wire logic run,
  output logic burst_env,
  output logic carrier_pulse
);
  // carrier stays low while the burst is off
  initial begin
    burst_env = 1'b0;
    carrier_pulse = 1'b0;
    // start 1 ns off the clock grid so no pin edge meets a sampling edge
    wait (run === 1'b1);
    #1;
    forever begin
      wait (run === 1'b1);
      #(OFF_NS);
      burst_env = 1'b1;
      repeat (ON_NS / 40) begin
        #20 carrier_pulse = 1'b1;
        #20 carrier_pulse = 1'b0;
      end
      burst_env = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench of the burst gate timing block
// assumes the envelope model runs 3 us on, 2 us off, carrier 40 ns
`timescale 1ns/100ps
`default_nettype none
`include "bgm_params.svh"
module tb_top;
  // ************
  // signals
  // ************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic run = 1'b0;
  logic ext_trig = 1'b0;
  logic line_trig = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire hreadyout;
  wire hresp;
  wire gate_en;
  wire reciprocal;
  wire burst_env;
  wire carrier_pulse;
  wire [31:0] hrdata;
  int num_errors = 0;
  int checked = 0;

  always #4 clk = ~clk;

  bgm_top bgm_top_inst(.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .burst_env(burst_env), .carrier_pulse(carrier_pulse), .ext_trig(ext_trig), .line_trig(line_trig),
    .gate_en(gate_en), .reciprocal(reciprocal));
  bgm_env_model bgm_env_model_inst(.run(run), .burst_env(burst_env), .carrier_pulse(carrier_pulse));

  // ************
  // shared tasks
  // ************
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask

  task automatic wait_valid;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      rd(`BGM_OFS_STAT, s);
      n++;
    end while (s[2] !== 1'b1 && n < 2000);
    if (s[2] !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, s, 32'h4);
    end
  endtask

  // ************
  // scenarios
  // ************
  task automatic t_reset;
    logic [31:0] r;
    rd(`BGM_OFS_CTRL, r);
    chk(r, 32'h10, 32'h10);
    rd(`BGM_OFS_POL, r);
    chk(r, 32'h0, 32'h0);
    rd(`BGM_OFS_MANF, r);
    chk(r, 32'h4e20, 32'h4e20);
    rd(`BGM_OFS_DELAY, r);
    chk(r, 32'h0, 32'h0);
    rd(`BGM_OFS_WIDTH, r);
    chk(r, 32'h3e8, 32'h3e8);
    rd(8'h20, r);
    chk(r, 32'h0, 32'h0);
    chk(reciprocal, 32'h1, 32'h1);
    chk(hresp, 32'h0, 32'h0);
    chk(gate_en, 32'h0, 32'h0);
  endtask

  task automatic t_recip(input logic [31:0] ctrl, input logic [31:0] e);
    wr(`BGM_OFS_CTRL, ctrl);
    @(negedge clk);
    chk(reciprocal, e, e);
    @(posedge clk);
  endtask

  task automatic t_step(input logic [7:0] a, input logic [31:0] v, input logic [3:0] b, input logic [31:0] e);
    logic [31:0] r;
    wr(a, v);
    wr(`BGM_OFS_STEP, {28'h0, b});
    rd(a, r);
    chk(r, e, e);
  endtask

  task automatic t_flags;
    logic [31:0] r;
    wr(`BGM_OFS_POL, 32'h1);
    rd(`BGM_OFS_POL, r);
    chk(r[0], 32'h1, 32'h1);
    wr(`BGM_OFS_POL, 32'h1);
    rd(`BGM_OFS_POL, r);
    chk(r[0], 32'h0, 32'h0);
    wr(`BGM_OFS_CTRL, 32'h19);
    wr(`BGM_OFS_MANF, 32'd999);
    rd(`BGM_OFS_STAT, r);
    chk(r[4], 32'h0, 32'h0);
    wr(`BGM_OFS_MANF, 32'd1000);
    rd(`BGM_OFS_STAT, r);
    chk(r[4], 32'h1, 32'h1);
  endtask

  task automatic t_gate(input logic [31:0] ctrl, input logic [31:0] gw, input logic [31:0] manf,
    input int glo, input int ghi, input int clo, input int chi);
    logic [31:0] r;
    int d;
    int g;
    wr(`BGM_OFS_MANF, manf);
    wr(`BGM_OFS_DELAY, 32'd80);
    wr(`BGM_OFS_WIDTH, gw);
    wr(`BGM_OFS_CTRL, ctrl);
    rd(`BGM_OFS_RES, r);
    @(negedge burst_env);
    @(posedge burst_env);
    d = 0;
    g = 0;
    while (gate_en !== 1'b1 && d < 3000) begin
      @(negedge clk);
      d++;
    end
    while (gate_en === 1'b1 && g < 3000) begin
      @(negedge clk);
      g++;
    end
    chk(d, 10, 16);
    chk(g, glo, ghi);
    @(posedge clk);
    wait_valid;
    rd(`BGM_OFS_RES, r);
    chk(r, clo, chi);
  endtask

  task automatic t_meas(input logic [31:0] ctrl, input int lo, input int hi);
    logic [31:0] r;
    wr(`BGM_OFS_CTRL, ctrl);
    rd(`BGM_OFS_RES, r);
    wait_valid;
    rd(`BGM_OFS_RES, r);
    wait_valid;
    rd(`BGM_OFS_RES, r);
    chk(r, lo, hi);
  endtask

  task automatic t_cw_idle;
    logic [31:0] r;
    wr(`BGM_OFS_CTRL, 32'h12);
    rd(`BGM_OFS_RES, r);
    repeat (1400) @(posedge clk);
    rd(`BGM_OFS_STAT, r);
    chk(r[2], 32'h0, 32'h0);
  endtask

  task automatic t_trig(input logic [31:0] ctrl, input logic ext, input int rise_n, input int fall_n);
    int n;
    wr(`BGM_OFS_DELAY, 32'd0);
    wr(`BGM_OFS_WIDTH, 32'd200);
    wr(`BGM_OFS_CTRL, ctrl);
    // pin rises, then falls; only the selected edge may open a gate
    if (ext) ext_trig <= 1'b1;
    else line_trig <= 1'b1;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (gate_en === 1'b1) n++;
    end
    chk(n, rise_n, rise_n);
    @(posedge clk);
    if (ext) ext_trig <= 1'b0;
    else line_trig <= 1'b0;
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (gate_en === 1'b1) n++;
    end
    chk(n, fall_n, fall_n);
    @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ************
  // main sequence
  // ************
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    run <= 1'b1;
    @(posedge clk);
    t_reset;
    t_recip(32'h100, 32'h0);
    t_recip(32'h101, 32'h1);
    t_step(`BGM_OFS_DELAY, 32'd0, 4'h2, 32'd0);
    t_step(`BGM_OFS_DELAY, 32'd300, 4'h1, 32'd320);
    t_step(`BGM_OFS_DELAY, 32'd320, 4'h1, 32'd360);
    t_step(`BGM_OFS_DELAY, 32'd320, 4'h2, 32'd300);
    t_step(`BGM_OFS_DELAY, 32'd1000, 4'h1, 32'd1100);
    t_step(`BGM_OFS_DELAY, 32'd100000000, 4'h1, 32'd100000000);
    t_step(`BGM_OFS_WIDTH, 32'd100, 4'h8, 32'd100);
    t_step(`BGM_OFS_WIDTH, 32'd100, 4'h4, 32'd120);
    t_step(`BGM_OFS_WIDTH, 32'd1000, 4'h8, 32'd980);
    t_step(`BGM_OFS_WIDTH, 32'd1000, 4'h4, 32'd1100);
    t_flags;
    t_gate(32'h11, 32'd200, 32'd1000, 125, 125, 24, 26);
    t_gate(32'h19, 32'd200, 32'd999, 125, 125, 24, 26);
    t_gate(32'h19, 32'd200, 32'd1000, 25, 25, 4, 6);
    t_gate(32'h01, 32'd200, 32'd1000, 355, 375, 70, 76);
    t_meas(32'h13, 370, 380);
    t_meas(32'h15, 620, 630);
    wr(`BGM_OFS_POL, 32'h1);
    t_meas(32'h13, 245, 255);
    t_meas(32'h15, 620, 630);
    t_cw_idle;
    t_trig(32'h79, 1'b1, 0, 25);
    t_trig(32'h99, 1'b0, 25, 0);
    tally_and_finish;
  end

  // hang guard
  initial begin
    // about four times the expected length of the run
    #400000;
    num_errors++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
